/* rtl/dres_top.v */
// Enable gating and status registers for a high (12 V) and a low
// (3.3 V) hot-swap rail.
// Assumes analog comparators arrive as clean levels on sys_clk and that a
// serial bus front end supplies byte reads at documented offsets.
`timescale 1ns/1ps
module dres_top (
   input  wire       sys_clk,
   input  wire       sys_rst,
   input  wire       hiRailEnablePin,
   input  wire       loRailEnablePin,
   input  wire       hiRailEnableBit,
   input  wire       loRailEnableBit,
   input  wire       hiRailBleedDownBit,
   input  wire       loRailBleedDownBit,
   input  wire       crossLinkDisable,
   input  wire       hiRailOutputAboveBleed,
   input  wire       loRailOutputAboveBleed,
   input  wire       loRailPowerGood,
   input  wire       hiRailPassAboveStart,
   input  wire       loRailReverseOn,
   input  wire       loRailGateAboveSource,
   input  wire       hiPowerGoodEvent,
   input  wire       hiTimeoutEvent,
   input  wire       loPowerGoodEvent,
   input  wire       loTimeoutEvent,
   input  wire       hiOvercurrentEvent,
   input  wire       hiFastTripEvent,
   input  wire       loOvercurrentEvent,
   input  wire       loFastTripEvent,
   input  wire       regRead,
   input  wire [7:0] regAddr,
   output reg  [7:0] regReadData,
   output wire       hiRailBlockGate,
   output wire       hiRailPassGate,
   output wire       loRailOn
);
`include "dres_defs.vh"

   // ----------------------------------------------------------------------
   // Startup hold
   // ----------------------------------------------------------------------
   reg  [2:0] startCnt_q;
   reg        started_q;

   // Power-on reset stands in for the internal rail crossing its threshold
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         startCnt_q <= 3'h0;
         started_q  <= 1'b0;
      end else if (!started_q) begin
         startCnt_q <= startCnt_q + 3'h1;
         if (startCnt_q == (`DRES_STARTUP_CYCLES - 3'h1)) begin
            started_q <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Enable conditions
   // ----------------------------------------------------------------------
   // Pin is assumed to read high when floating, via the pad pull-up
   wire loEnable = started_q & loRailEnablePin
                   & loRailEnableBit
                   & (loRailOutputAboveBleed
                      | ~loRailBleedDownBit);
   wire hiEnable = started_q & hiRailEnablePin
                   & hiRailEnableBit
                   & (hiRailOutputAboveBleed
                      | ~hiRailBleedDownBit)
                   & (loRailPowerGood
                      | crossLinkDisable);

   reg hiOn_q;
   reg loOn_q;
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         hiOn_q <= 1'b0;
         loOn_q <= 1'b0;
      end else begin
         hiOn_q <= hiEnable;
         loOn_q <= loEnable;
      end
   end

   assign hiRailBlockGate = hiOn_q;
   assign hiRailPassGate  = hiOn_q;
   assign loRailOn        = loOn_q;

   // ----------------------------------------------------------------------
   // Latched status
   // ----------------------------------------------------------------------
   wire readChan = regRead & (regAddr == `DRES_REG_LATCH_CHAN);
   wire readOc   = regRead & (regAddr == `DRES_REG_LATCH_OC);
   wire [3:0] chanLatched;
   wire [3:0] ocLatched;

   dres_status_latch #(.WIDTH(4)) uChan (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .eventIn   ({loTimeoutEvent, loPowerGoodEvent,
                   hiTimeoutEvent, hiPowerGoodEvent}),
      .readClear (readChan),
      .latched   (chanLatched)
   );

   dres_status_latch #(.WIDTH(4)) uOc (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .eventIn   ({loFastTripEvent, loOvercurrentEvent,
                   hiFastTripEvent, hiOvercurrentEvent}),
      .readClear (readOc),
      .latched   (ocLatched)
   );

   // ----------------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------------
   reg [7:0] rdMux;
   always @* begin
      rdMux = 8'h00;
      if (regAddr == `DRES_REG_LATCH_CHAN) begin
         rdMux[`DRES_BIT_HI_PG]  = chanLatched[0];
         rdMux[`DRES_BIT_HI_FLT] = chanLatched[1];
         rdMux[`DRES_BIT_LO_PG]  = chanLatched[2];
         rdMux[`DRES_BIT_LO_FLT] = chanLatched[3];
      end else if (regAddr == `DRES_REG_LATCH_OC) begin
         rdMux[`DRES_BIT_HI_OC]  = ocLatched[0];
         rdMux[`DRES_BIT_HI_FTR] = ocLatched[1];
         rdMux[`DRES_BIT_LO_OC]  = ocLatched[2];
         rdMux[`DRES_BIT_LO_FTR] = ocLatched[3];
      end else if (regAddr == `DRES_REG_LIVE_FET) begin
         rdMux[`DRES_BIT_HI_BLOCK]   = hiOn_q;
         rdMux[`DRES_BIT_HI_PASS]    = ~hiRailPassAboveStart;
         rdMux[`DRES_BIT_LO_REVERSE] = ~loRailReverseOn;
         rdMux[`DRES_BIT_LO_GATE]    = ~loRailGateAboveSource;
      end
   end

   always @(posedge sys_clk) begin
      if (sys_rst) begin
         regReadData <= `DRES_READ_DATA_RESET;
      end else if (regRead) begin
         regReadData <= rdMux;
      end
   end
endmodule

/* rtl/dres_defs.vh */
// Register offsets, field positions, reset values and timing for the
// dual rail enable and status block.
// Assumes inclusion by bare name from the design files only.
//
// Behaviour
// - Status bit 3 mirrors block gate drive
// - Status bit 4 low when pass gate high
// - Status bit 5 low when reverse block on
// - Status bit 7 low when low gate on
// - Startup holds both rails off
// - Power-on reset loads register defaults
// - Low enable pin floating counts as high
// - Each rail needs its software enable bit
// - Bleed-down holds rail off until output above bleed level
// - Cross link drops high rail on low loss
// - Cross link disable bit keeps high rail
// - Low rail enable condition conjunction
// - High rail enable condition conjunction
// - Twelve status bits over three registers
// - Register 7 power-good and timeout positions
// - Register 8 overcurrent positions
// - Register 8 fast trip positions
// - Register 7 latched until read
// - Register 8 latched until read
`ifndef DRES_DEFS_VH
`define DRES_DEFS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define DRES_REG_LATCH_CHAN   8'h07
`define DRES_REG_LATCH_OC     8'h08
`define DRES_REG_LIVE_FET     8'h09

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define DRES_BIT_HI_PG        4
`define DRES_BIT_HI_FLT       5
`define DRES_BIT_LO_PG        6
`define DRES_BIT_LO_FLT       7
`define DRES_BIT_HI_OC        4
`define DRES_BIT_HI_FTR       5
`define DRES_BIT_LO_OC        6
`define DRES_BIT_LO_FTR       7
`define DRES_BIT_HI_BLOCK     3
`define DRES_BIT_HI_PASS      4
`define DRES_BIT_LO_REVERSE   5
`define DRES_BIT_LO_GATE      7

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define DRES_LATCH_RESET      4'h0
`define DRES_READ_DATA_RESET  8'h00
`define DRES_STARTUP_CYCLES   3'h4

`endif

/* rtl/dres_status_latch.v */
// Four sticky status bits cleared by a read strobe.
// Assumes events and the read strobe are synchronous to sys_clk.
`timescale 1ns/1ps
module dres_status_latch #(
   parameter WIDTH = 4
) (
   input  wire             sys_clk,
   input  wire             sys_rst,
   input  wire [WIDTH-1:0] eventIn,
   input  wire             readClear,
   output wire [WIDTH-1:0] latched
);
`include "dres_defs.vh"

   reg [WIDTH-1:0] latch_q;
   reg [WIDTH-1:0] latch_d;

   // A new event in the clearing cycle survives the clear
   always @* begin
      latch_d = readClear ? eventIn : (latch_q | eventIn);
   end

   always @(posedge sys_clk) begin
      if (sys_rst) begin
         latch_q <= {WIDTH{1'b0}};
      end else begin
         latch_q <= latch_d;
      end
   end

   assign latched = latch_q;
endmodule

/* tb/dres_host.sv */
// Host model: single-byte reads of the status registers.
// Assumes requests may change on the falling edge of sys_clk.
`timescale 1ns/1ps
module dres_host (
   input  wire       sys_clk,
   output reg        regRead = 1'b0,
   output reg  [7:0] regAddr = 8'h00,
   input  wire [7:0] regReadData
);
   task rd(input [7:0] a, output [7:0] d);
      @(negedge sys_clk) regRead = 1'b1;
      regAddr = a;
      @(negedge sys_clk) regRead = 1'b0;
      regAddr = ~a;
      d = regReadData;
   endtask
endmodule

/* tb/dres_top_chk.sv */
// Checker for dres_top: rail gating and status read-back.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module dres_chk (
   input wire       sys_clk,
   input wire       sys_rst,
   input wire       regRead,
   input wire       loRailOn,
   input wire       hiRailPassGate,
   input wire       hiRailBlockGate,
   input wire       hiTimeoutEvent,
   input wire       loFastTripEvent,
   input wire       loRailEnablePin,
   input wire       loRailEnableBit,
   input wire       loRailBleedDownBit,
   input wire       hiRailEnablePin,
   input wire       hiRailEnableBit,
   input wire       hiRailBleedDownBit,
   input wire       loRailOutputAboveBleed,
   input wire       hiRailOutputAboveBleed,
   input wire       loRailPowerGood,
   input wire       crossLinkDisable,
   input wire       loRailReverseOn,
   input wire       hiRailPassAboveStart,
   input wire       loRailGateAboveSource,
   input wire [7:0] regAddr,
   input wire [7:0] regReadData
);
   wire loOk = loRailEnablePin & loRailEnableBit &
               (loRailOutputAboveBleed | ~loRailBleedDownBit);
   wire hiOk = hiRailEnablePin & hiRailEnableBit &
               (hiRailOutputAboveBleed | ~hiRailBleedDownBit) &
               (loRailPowerGood | crossLinkDisable);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   a_startup_off: assert property (
      $fell(sys_rst) |-> (!loRailOn && !hiRailBlockGate) [*5])
      else $error("rail on at startup");
   a_lo_cause: assert property (
      loRailOn |-> $past(loOk)) else $error("lo on unasked");
   a_lo_hold: assert property (
      loRailOn && loOk |=> loRailOn) else $error("lo dropped");
   a_hi_cause: assert property (
      hiRailPassGate |-> $past(hiOk)) else $error("hi on unasked");
   a_hi_hold: assert property (
      hiRailPassGate && hiOk |=> hiRailPassGate) else $error("hi dropped");
   a_live_map: assert property (
      regRead && regAddr == 8'h09 |=> regReadData ==
      {~$past(loRailGateAboveSource), 1'b0, ~$past(loRailReverseOn),
      ~$past(hiRailPassAboveStart), $past(hiRailBlockGate), 3'h0})
      else $error("live status wrong");
   a_chan_sticky: assert property (
      hiTimeoutEvent ##1 (regRead && regAddr == 8'h07) |=> regReadData[5])
      else $error("timeout lost");
   a_oc_sticky: assert property (
      loFastTripEvent ##1 (regRead && regAddr == 8'h08) |=> regReadData[7])
      else $error("fast trip lost");
   cover property (loRailOn);
   cover property (hiRailPassGate);
   cover property (regRead && regAddr == 8'h08);
   cover property (hiTimeoutEvent && regRead && regAddr == 8'h07);
endmodule
bind dres_top dres_chk i_dres_chk (.*);

/* tb/dres_top_bench.sv */
// Self-checking bench for dres_top driven through dres_host reads.
// Assumes inputs move on the falling edge of sys_clk.
`timescale 1ns/1ps
module dres_top_bench;
   reg        sys_clk = 1'b0;
   reg        sys_rst = 1'b1;
   reg  [9:0] cfg = 10'h1ff;
   reg  [7:0] ev = 8'h00;
   reg  [2:0] live = 3'h0;
   reg  [7:0] d, x;
   wire       regRead, loRailOn, hiRailBlockGate, hiRailPassGate;
   wire [7:0] regAddr, regReadData;
   integer    mismatches = 0, comparisons = 0, i;
   dres_host i_dres_host (.*);
   dres_top i_dres_top (.*, .loRailEnablePin(cfg[0]),
      .loRailEnableBit(cfg[1]), .loRailBleedDownBit(cfg[2]),
      .loRailOutputAboveBleed(cfg[3]), .hiRailEnablePin(cfg[4]),
      .hiRailEnableBit(cfg[5]), .hiRailBleedDownBit(cfg[6]),
      .hiRailOutputAboveBleed(cfg[7]), .loRailPowerGood(cfg[8]),
      .crossLinkDisable(cfg[9]), .hiRailPassAboveStart(live[0]),
      .loRailReverseOn(live[1]), .loRailGateAboveSource(live[2]),
      .hiPowerGoodEvent(ev[0]), .hiTimeoutEvent(ev[1]),
      .loPowerGoodEvent(ev[2]), .loTimeoutEvent(ev[3]),
      .hiOvercurrentEvent(ev[4]), .hiFastTripEvent(ev[5]),
      .loOvercurrentEvent(ev[6]), .loFastTripEvent(ev[7]));
   always #10 sys_clk = ~sys_clk;
   task check(input [39:0] what, input [7:0] exp, got);
      comparisons = comparisons + 1;
      if (got !== exp) begin
         mismatches = mismatches + 1;
         $display("MISMATCH %0s exp %h got %h", what, exp, got);
      end
   endtask
   task rdChk(input [7:0] a, exp);
      i_dres_host.rd(a, d);
      check("read", exp, d);
   endtask
   task tRails(input [9:0] c);
      reg hi;
      hi = c[4] & c[5] & (c[7] | ~c[6]) & (c[8] | c[9]);
      @(negedge sys_clk) cfg = c;
      @(negedge sys_clk);
      check("lo", c[0] & c[1] & (c[3] | ~c[2]), loRailOn);
      check("hi", {2{hi}}, {hiRailPassGate, hiRailBlockGate});
   endtask
   // Rails must stay off for exactly four cycles after release
   task tStartup;
      repeat (4) begin
         @(negedge sys_clk);
         check("start", 8'h00,
               {loRailOn, hiRailPassGate, hiRailBlockGate});
      end
      @(negedge sys_clk);
      check("up", 8'h07,
            {loRailOn, hiRailPassGate, hiRailBlockGate});
      rdChk(8'h07, 8'h00);
      rdChk(8'h08, 8'h00);
   endtask
   // Mid-run reset must drop the rails and wipe every latched bit
   task tReset;
      @(negedge sys_clk) ev = 8'hff;
      @(negedge sys_clk) ev = 8'h00;
      sys_rst = 1'b1;
      repeat (2) @(negedge sys_clk);
      sys_rst = 1'b0;
      tStartup;
   endtask
   task tEnables;
      reg [109:0] t;
      t = {10'h1ff, 10'h0ff, 10'h2ff, 10'h1fe, 10'h1fd, 10'h1df,
           10'h1f7, 10'h1f3, 10'h17f, 10'h13f, 10'h1ef};
      for (i = 0; i < 11; i = i + 1)
         tRails(t[i*10 +: 10]);
   endtask
   task tLive;
      for (i = 0; i < 16; i = i + 1) begin
         @(negedge sys_clk) cfg = i[3] ? 10'h1ff : 10'h000;
         live = i[2:0];
         x = {~i[2], 1'b0, ~i[1:0], i[3], 3'h0};
         rdChk(8'h09, x);
      end
   endtask
   task tLatch;
      reg [7:0] e, p, q;
      for (i = 0; i < 2; i = i + 1) begin
         e = i ? 8'he9 : 8'h96;
         p = {e[3:0], 4'h0};
         q = {e[7:4], 4'h0};
         @(negedge sys_clk) ev = e;
         fork
            i_dres_host.rd(i ? 8'h08 : 8'h07, d);
            @(negedge sys_clk) ev = 8'h00;
         join
         check("first", i ? q : p, d);
         rdChk(i ? 8'h07 : 8'h08, i ? p : q);
         rdChk(8'h07, 8'h00);
         rdChk(8'h08, 8'h00);
      end
      // An event in the clearing cycle must survive the clear
      fork
         i_dres_host.rd(8'h07, d);
         begin
            @(negedge sys_clk) ev = 8'h02;
            @(negedge sys_clk) ev = 8'h00;
         end
      join
      check("clash", 8'h00, d);
      rdChk(8'h07, 8'h20);
      rdChk(8'h0a, 8'h00);
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (8) @(negedge sys_clk);
      sys_rst = 1'b0;
      tStartup;
      tEnables;
      tLive;
      tLatch;
      tReset;
      finish_test;
   end
   initial begin
      #40000;
      mismatches = mismatches + 1;
      finish_test;
   end
endmodule
